// ### logic/pdm_pkg.sv
// shared constants and types of the power-down mode controller
package pdm_pkg;
	// power states, gray coded along run-halt-sleep-stop-idle-standby
	typedef enum logic [2:0] {
		PDM_RUN = 3'h0,
		PDM_HALT = 3'h1,
		PDM_SLEEP = 3'h3,
		PDM_SYSSTOP = 3'h2,
		PDM_IDLE = 3'h6,
		PDM_STANDBY = 3'h7,
		PDM_RECOVER = 3'h5,
		PDM_BUSHOLD = 3'h4
	} pdm_state_t;

	// avalon byte offsets
	localparam logic [3:0] PDM_OFS_CPU_CTRL = 4'h0;
	localparam logic [3:0] PDM_OFS_IO_CTRL = 4'h4;
	localparam logic [3:0] PDM_OFS_INT_EN = 4'h8;
	localparam logic [3:0] PDM_OFS_STATUS = 4'hC;

	// cpu_control_register fields
	localparam int PDM_CCR_SEL_HI = 6;
	localparam int PDM_CCR_BUS_WAKE = 5;
	localparam int PDM_CCR_SEL_LO = 3;
	localparam logic [7:0] PDM_CCR_RESET = 8'h00;
	// io_control_register fields
	localparam int PDM_ICR_PERIPH_STOP = 5;
	localparam logic [7:0] PDM_ICR_MASK = 8'hE0;
	localparam logic [7:0] PDM_ICR_RESET = 8'h00;
	// interrupt enables: external 0..2, bit 3 on-chip peripherals
	localparam int PDM_NUM_EXT_INT = 3;
	localparam int PDM_IEN_PERIPH = 3;
	localparam logic [3:0] PDM_IEN_RESET = 4'h0;

	// timing, all counted in 40 MHz clocks
	localparam int PDM_CLK_MHZ = 40;
	localparam int PDM_RESET_MIN_CLOCKS = 6;
	localparam int PDM_WAKE_HALF_CLOCKS = 3;
	localparam int PDM_WAKE_CYCLES = (PDM_WAKE_HALF_CLOCKS + 1) / 2;
	localparam int PDM_IDLE_CLOCKS = 8;
	localparam int PDM_IDLE_CYCLES = PDM_IDLE_CLOCKS + PDM_WAKE_CYCLES;
	localparam int PDM_QUICK_LOG2 = 6;
	localparam int PDM_QUICK_CYCLES = (1 << PDM_QUICK_LOG2) + PDM_WAKE_CYCLES;
	localparam int PDM_STANDBY_LOG2 = 17;
	localparam int PDM_STANDBY_CYCLES =
		(1 << PDM_STANDBY_LOG2) + PDM_WAKE_CYCLES;
	localparam int PDM_STAB_WIDTH = 18;
endpackage

// ### logic/pdm_cnt_if.sv
// link between the controller and its stabilisation counter
interface pdm_cnt_if #(
	parameter int W = 18
);
	logic load;
	logic [W-1:0] value;
	logic done;
	modport ctl (output load, output value, input done);
	modport cnt (input load, input value, output done);
endinterface

// ### logic/pdm_stab_counter.sv
// reloadable down counter for oscillator stabilisation and wake delays
module pdm_stab_counter #(
	parameter int W = 18
) (
	input wire logic clk,
	input wire logic rst,
	pdm_cnt_if.cnt cnt_port
);
	import pdm_pkg::*;

	logic [W-1:0] count;

	// a load always restarts from the full value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (cnt_port.load) begin
			count <= cnt_port.value;
		end else if (count != '0) begin
			count <= count - W'(1);
		end
	end

	assign cnt_port.done = (count == '0) && !cnt_port.load;
endmodule

// ### logic/pdm_power_ctrl.sv
// power-down mode controller: halt, sleep, stop, idle and standby
// Behaviour
// RL1: halt opcode stops execution, cpu clock keeps running.
// RL2: halted: interrupts, bus exchange, refresh, dma run; halt low; dummy fetch.
// RL3: reset low six clocks while halted restarts at address zero.
// RL4: unmasked interrupt or nmi ends halt; masked one leaves it halted.
// RL5: sleep instruction enters sleep.
// RL6: sleep stops cpu clock, refresh, dma; oscillator, peripherals, grant run.
// RL7: sleep drives address high, controls inactive high, data floating.
// RL8: reset low six clocks in sleep restarts at address zero.
// RL9: nmi ends sleep with the nmi response.
// RL10: disabled interrupt ignored; enabled one with global enable responds.
// RL11: enabled interrupt, global enable clear: wake and continue after sleep.
// RL12: peripheral stop bit halts serial and timers; clearing resumes them.
// RL13: stop bit plus sleep stops all; peripherals cannot wake it.
// RL14: recovery 1.5 clocks sleep, 8+1.5 idle, count+1.5 standby.
// RL15: standby entry: ccr bits 6,3 = 1,0, stop bit set, sleep.
// RL16: standby also stops oscillator, internal clocks and clock output.
// RL17: external interrupt or bus request restarts oscillator, counts 2^17.
// RL18: source must hold for whole count, else back to standby.
// RL19: bus wake bit set: bus request wakes standby, bus released, grant.
// RL20: bus request withdrawn: retake bus, drive high, leave standby.
// RL21: bus wake bit clear: bus request does not wake standby.
// RL22: after reset or interrupt exit, bus stays released while requested.
// RL23: idle entry bits 6,3 = 0,1; oscillator runs, clocks gated.
// RL24: idle exit skips long count, controls back eight clocks later.
// RL25: ccr bits 6,3 both set: quick standby with 2^6 count.
// RL26: exactly one power state held; reset returns to run.
// RL27: stabilisation counter reloaded in full at each recovery start.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
module pdm_power_ctrl #(
	parameter int STANDBY_CYCLES = pdm_pkg::PDM_STANDBY_CYCLES,
	parameter int QUICK_CYCLES = pdm_pkg::PDM_QUICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic reset_pin_n,
	input wire logic halt_exec,
	input wire logic sleep_instruction,
	input wire logic nmi_n,
	input wire logic [pdm_pkg::PDM_NUM_EXT_INT-1:0] ext_int_req,
	input wire logic periph_int_req,
	input wire logic global_interrupt_enable_flag,
	input wire logic bus_request_input_n,
	output logic bus_grant_output_n,
	output logic bus_float,
	output logic address_outputs_high,
	output logic ctrl_inactive,
	output logic data_float,
	output logic halt_n,
	output logic halt_dummy_fetch,
	output logic cpu_clk_en,
	output logic refresh_en,
	output logic dma_controller_en,
	output logic peripheral_clk_en,
	output logic osc_en,
	output logic system_clock_output_en,
	output logic reset_seq_start,
	output logic int_response,
	output logic nmi_response,
	output logic resume_next
);
	import pdm_pkg::*;

	localparam int W = PDM_STAB_WIDTH;

	pdm_state_t state, next_state;
	logic [7:0] cpu_control_register;
	logic [7:0] io_control_register;
	logic [3:0] int_enable;
	logic [2:0] reset_low_count;
	logic nmi_prev, nmi_pend;
	logic cause_nmi, cause_bus, from_standby;
	logic next_cause_nmi, next_cause_bus, next_from_standby;
	logic next_int_resp, next_nmi_resp, next_resume;
	logic pin_reset_hit, wake_mask, ext_wake, bus_wake, src_held;
	logic peripheral_stop_bit, next_grant, next_quiet;
	logic bus_req, bus_ack;

	pdm_cnt_if #(.W(W)) stab_if ();

	pdm_stab_counter #(.W(W)) u_stab (
		.clk(clk),
		.rst(rst),
		.cnt_port(stab_if.cnt)
	);

	function automatic logic stopped(input pdm_state_t s);
		stopped = (s == PDM_SLEEP) || (s == PDM_SYSSTOP) ||
			(s == PDM_IDLE) || (s == PDM_STANDBY) || (s == PDM_RECOVER);
	endfunction

	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h0, v};
	endfunction

	assign peripheral_stop_bit = io_control_register[PDM_ICR_PERIPH_STOP];
	assign bus_req = !bus_request_input_n;
	assign pin_reset_hit =
		(reset_low_count == 3'(PDM_RESET_MIN_CLOCKS - 1)) && !reset_pin_n;

	// ---------------- avalon slave ----------------
	// one wait cycle per access; write lands when waitrequest is low
	assign bus_ack = (avs_read || avs_write) && !avs_waitrequest;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				PDM_OFS_CPU_CTRL: avs_readdata <= zext8(cpu_control_register);
				PDM_OFS_IO_CTRL: avs_readdata <= zext8(io_control_register);
				PDM_OFS_INT_EN: avs_readdata <= {28'h0, int_enable};
				PDM_OFS_STATUS: avs_readdata <= {24'h0, stab_if.done,
					from_standby, cause_bus, cause_nmi, nmi_pend, state};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	// control registers, cleared again by a pin reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_control_register <= PDM_CCR_RESET;
			io_control_register <= PDM_ICR_RESET;
			int_enable <= PDM_IEN_RESET;
		end else if (pin_reset_hit) begin
			cpu_control_register <= PDM_CCR_RESET;
			io_control_register <= PDM_ICR_RESET;
			int_enable <= PDM_IEN_RESET;
		end else if (bus_ack && avs_write && avs_byteenable[0]) begin
			unique case (avs_address)
				PDM_OFS_CPU_CTRL: cpu_control_register <= avs_writedata[7:0];
				PDM_OFS_IO_CTRL:
					io_control_register <= avs_writedata[7:0] & PDM_ICR_MASK;
				PDM_OFS_INT_EN: int_enable <= avs_writedata[3:0];
				default: ;
			endcase
		end
	end

	// ---------------- reset pin and nmi ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_low_count <= 3'h0;
		end else if (reset_pin_n) begin
			reset_low_count <= 3'h0;
		end else if (!pin_reset_hit) begin
			reset_low_count <= reset_low_count + 3'h1;
		end
	end

	// nmi is edge triggered and latched; a new edge beats the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nmi_prev <= 1'b1;
			nmi_pend <= 1'b0;
		end else begin
			nmi_prev <= nmi_n;
			if (nmi_prev && !nmi_n) begin
				nmi_pend <= 1'b1; // [RL9]
			end else if (next_nmi_resp || pin_reset_hit) begin
				nmi_pend <= 1'b0;
			end
		end
	end

	// ---------------- next state ----------------
	always_comb begin
		// stopped peripherals cannot raise a wake request
		wake_mask = (|(ext_int_req & int_enable[PDM_NUM_EXT_INT-1:0])) ||
			(periph_int_req && int_enable[PDM_IEN_PERIPH] &&
			!peripheral_stop_bit); // [RL10] [RL13]
		ext_wake = |(ext_int_req & int_enable[PDM_NUM_EXT_INT-1:0]);
		bus_wake = bus_req &&
			cpu_control_register[PDM_CCR_BUS_WAKE]; // [RL19] [RL21]
		src_held = cause_nmi || (cause_bus ? bus_wake : ext_wake);
		next_state = state;
		next_cause_nmi = cause_nmi;
		next_cause_bus = cause_bus;
		next_from_standby = from_standby;
		next_int_resp = 1'b0;
		next_nmi_resp = 1'b0;
		next_resume = 1'b0;
		stab_if.load = 1'b0;
		stab_if.value = W'(PDM_WAKE_CYCLES);
		unique case (state)
			PDM_RUN: begin
				if (halt_exec) begin
					next_state = PDM_HALT; // [RL1]
				end else if (sleep_instruction) begin
					if (!peripheral_stop_bit) begin
						next_state = PDM_SLEEP; // [RL5]
					end else if (cpu_control_register[PDM_CCR_SEL_HI]) begin
						next_state = PDM_STANDBY; // [RL15] [RL25]
					end else if (cpu_control_register[PDM_CCR_SEL_LO]) begin
						next_state = PDM_IDLE; // [RL23]
					end else begin
						next_state = PDM_SYSSTOP; // [RL13]
					end
				end
			end
			PDM_HALT: begin
				if (nmi_pend) begin
					next_state = PDM_RUN; // [RL4]
					next_nmi_resp = 1'b1;
				end else if (wake_mask && global_interrupt_enable_flag) begin
					next_state = PDM_RUN; // [RL4]
					next_int_resp = 1'b1;
				end
			end
			PDM_SLEEP, PDM_SYSSTOP: begin
				if (nmi_pend || wake_mask) begin
					next_state = PDM_RECOVER; // [RL14]
					next_cause_nmi = nmi_pend;
					next_cause_bus = 1'b0;
					next_from_standby = 1'b0;
					stab_if.load = 1'b1;
				end
			end
			PDM_IDLE: begin
				if (nmi_pend || ext_wake || bus_wake) begin
					next_state = PDM_RECOVER; // [RL24]
					next_cause_nmi = nmi_pend;
					next_cause_bus = !nmi_pend && !ext_wake;
					next_from_standby = 1'b0;
					stab_if.load = 1'b1;
					stab_if.value = W'(PDM_IDLE_CYCLES);
				end
			end
			PDM_STANDBY: begin
				if (nmi_pend || ext_wake || bus_wake) begin
					next_state = PDM_RECOVER; // [RL17]
					next_cause_nmi = nmi_pend;
					next_cause_bus = !nmi_pend && !ext_wake;
					next_from_standby = 1'b1;
					stab_if.load = 1'b1; // [RL27]
					stab_if.value = cpu_control_register[PDM_CCR_SEL_LO] ?
						W'(QUICK_CYCLES) : W'(STANDBY_CYCLES); // [RL25]
				end
			end
			PDM_RECOVER: begin
				if (from_standby && !src_held) begin
					next_state = PDM_STANDBY; // [RL18]
				end else if (stab_if.done) begin
					if (cause_nmi) begin
						next_state = PDM_RUN; // [RL9]
						next_nmi_resp = 1'b1;
					end else if (cause_bus) begin
						next_state = PDM_BUSHOLD; // [RL19]
					end else begin
						next_state = PDM_RUN;
						next_int_resp = global_interrupt_enable_flag; // [RL10]
						next_resume = !global_interrupt_enable_flag; // [RL11]
					end
				end
			end
			PDM_BUSHOLD: begin
				if (!bus_req) begin
					next_state = PDM_RUN; // [RL20]
					next_resume = 1'b1;
				end
			end
		endcase
		if (pin_reset_hit) begin
			next_state = PDM_RUN; // [RL3] [RL8] [RL26]
			next_int_resp = 1'b0;
			next_nmi_resp = 1'b0;
			next_resume = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= PDM_RUN; // [RL26]
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cause_nmi <= 1'b0;
			cause_bus <= 1'b0;
			from_standby <= 1'b0;
		end else begin
			cause_nmi <= next_cause_nmi;
			cause_bus <= next_cause_bus;
			from_standby <= next_from_standby;
		end
	end

	// ---------------- bus ownership ----------------
	always_comb begin
		// granted in run, halt, sleep, stop and bus hold, never in idle, standby or recovery
		next_grant = bus_req && ((next_state == PDM_RUN) ||
			(next_state == PDM_HALT) || (next_state == PDM_SLEEP) ||
			(next_state == PDM_SYSSTOP) ||
			(next_state == PDM_BUSHOLD)); // [RL2] [RL6] [RL22]
		next_quiet = stopped(next_state) && !next_grant;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_grant_output_n <= 1'b1;
			bus_float <= 1'b0;
			address_outputs_high <= 1'b0;
			ctrl_inactive <= 1'b0;
			data_float <= 1'b0;
		end else begin
			bus_grant_output_n <= !next_grant; // [RL19]
			bus_float <= next_grant;
			address_outputs_high <= next_quiet; // [RL7] [RL20]
			ctrl_inactive <= next_quiet; // [RL7]
			data_float <= next_quiet || next_grant; // [RL7]
		end
	end

	// ---------------- clock and block enables ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_clk_en <= 1'b1;
			refresh_en <= 1'b1;
			dma_controller_en <= 1'b1;
			peripheral_clk_en <= 1'b1;
			osc_en <= 1'b1;
			system_clock_output_en <= 1'b1;
			halt_n <= 1'b1;
			halt_dummy_fetch <= 1'b0;
		end else begin
			cpu_clk_en <= !stopped(next_state) &&
				(next_state != PDM_BUSHOLD); // [RL1] [RL6]
			refresh_en <= (next_state == PDM_RUN) ||
				(next_state == PDM_HALT); // [RL2] [RL6]
			dma_controller_en <= (next_state == PDM_RUN) ||
				(next_state == PDM_HALT); // [RL6]
			peripheral_clk_en <= !io_control_register[PDM_ICR_PERIPH_STOP]
				&& !pin_reset_hit; // [RL12]
			osc_en <= next_state != PDM_STANDBY; // [RL16] [RL17]
			system_clock_output_en <= (next_state != PDM_IDLE) &&
				(next_state != PDM_STANDBY) &&
				(next_state != PDM_RECOVER || !next_cause_bus &&
				!next_from_standby && (state != PDM_IDLE)); // [RL16] [RL23]
			halt_n <= next_state != PDM_HALT; // [RL2]
			halt_dummy_fetch <= next_state == PDM_HALT; // [RL2]
		end
	end

	// ---------------- exit pulses ----------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_seq_start <= 1'b0;
			int_response <= 1'b0;
			nmi_response <= 1'b0;
			resume_next <= 1'b0;
		end else begin
			reset_seq_start <= pin_reset_hit; // [RL3] [RL8]
			int_response <= next_int_resp; // [RL4] [RL10]
			nmi_response <= next_nmi_resp; // [RL4] [RL9]
			resume_next <= next_resume; // [RL11]
		end
	end
endmodule

// ### bench/pdm_bus_master_model.sv
// alternate bus master holding its request as a steady level
module pdm_bus_master_model (
	input wire logic clk,
	input wire logic want,
	input wire logic bus_grant_output_n,
	output logic bus_request_input_n,
	output logic granted
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_request_input_n = 1'b1;
	// request follows want one clock later and stays low while want is high
	always @(posedge clk) begin
		bus_request_input_n <= ~want;
	end
	assign granted = ~bus_grant_output_n;
endmodule

// ### bench/pdm_power_ctrl_chk.sv
// port assertions of the power-down controller
module pdm_power_ctrl_chk #(
	parameter int STANDBY_CYCLES = 20,
	parameter int QUICK_CYCLES = 66
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic reset_pin_n,
	input wire logic halt_exec,
	input wire logic sleep_instruction,
	input wire logic nmi_n,
	input wire logic bus_grant_output_n,
	input wire logic bus_float,
	input wire logic address_outputs_high,
	input wire logic ctrl_inactive,
	input wire logic data_float,
	input wire logic halt_n,
	input wire logic halt_dummy_fetch,
	input wire logic cpu_clk_en,
	input wire logic refresh_en,
	input wire logic dma_controller_en,
	input wire logic osc_en,
	input wire logic system_clock_output_en,
	input wire logic reset_seq_start,
	input wire logic int_response,
	input wire logic nmi_response,
	input wire logic resume_next
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_access;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_pin_low;
		$fell(reset_pin_n) ##0 !reset_pin_n [*6];
	endsequence
	a_access_wait: assert property (s_access |=> !avs_waitrequest ##1
		avs_waitrequest) else $error("access not answered in one cycle");
	a_halt_entry: assert property (halt_exec && !sleep_instruction &&
		halt_n && cpu_clk_en && bus_grant_output_n && reset_pin_n |=> !halt_n)
		else $error("halt opcode did not halt");
	a_halt_running: assert property (!halt_n |-> cpu_clk_en && refresh_en &&
		dma_controller_en && halt_dummy_fetch) else $error("halt stopped work");
	a_sleep_bus: assert property (address_outputs_high |-> ctrl_inactive &&
		data_float && !refresh_en) else $error("stopped bus not parked");
	a_standby_clk: assert property (!osc_en |-> !system_clock_output_en &&
		!cpu_clk_en && address_outputs_high) else $error("clock left running");
	a_pin_reset: assert property (s_pin_low |-> ##[1:2] reset_seq_start)
		else $error("reset pin ignored");
	a_nmi_sleep: assert property ($fell(nmi_n) && !cpu_clk_en && osc_en &&
		system_clock_output_en && reset_pin_n |-> ##[1:6] nmi_response)
		else $error("nmi did not end sleep");
	a_grant_float: assert property (!bus_grant_output_n |-> bus_float &&
		data_float && !address_outputs_high)
		else $error("bus granted while driven");
	a_pulse_single: assert property ($onehot0({reset_seq_start,
		int_response, nmi_response, resume_next})) else $error("two wake pulses");
endmodule
bind pdm_power_ctrl pdm_power_ctrl_chk #(.STANDBY_CYCLES(STANDBY_CYCLES),
	.QUICK_CYCLES(QUICK_CYCLES)) i_pdm_power_ctrl_chk (.clk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .reset_pin_n, .halt_exec, .sleep_instruction,
	.nmi_n, .bus_grant_output_n, .bus_float, .address_outputs_high,
	.ctrl_inactive, .data_float, .halt_n, .halt_dummy_fetch, .cpu_clk_en,
	.refresh_en, .dma_controller_en, .osc_en, .system_clock_output_en,
	.reset_seq_start, .int_response, .nmi_response, .resume_next);

// ### bench/pdm_power_ctrl_tb.sv
// self-checking bench of the power-down controller
module pdm_power_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic reset_pin_n = 1'b1;
	logic halt_exec = 1'b0;
	logic sleep_instruction = 1'b0;
	logic nmi_n = 1'b1;
	logic [2:0] ext_int_req = 3'h0;
	logic gie = 1'b0;
	logic pint = 1'b0;
	logic want = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, bus_request_input_n, bus_grant_output_n, granted;
	logic bus_float, address_outputs_high, ctrl_inactive, data_float, halt_n;
	logic halt_dummy_fetch, cpu_clk_en, refresh_en, dma_controller_en;
	logic peripheral_clk_en, osc_en, system_clock_output_en, reset_seq_start;
	logic int_response, nmi_response, resume_next;
	int n_errors = 0;
	int tests_run = 0;
	always #12.5 clk = ~clk;
	pdm_power_ctrl #(.STANDBY_CYCLES(20)) i_pdm_power_ctrl (.clk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .reset_pin_n,
		.halt_exec, .sleep_instruction, .nmi_n, .ext_int_req,
		.periph_int_req(pint), .global_interrupt_enable_flag(gie),
		.bus_request_input_n, .bus_grant_output_n, .bus_float,
		.address_outputs_high, .ctrl_inactive, .data_float, .halt_n,
		.halt_dummy_fetch, .cpu_clk_en, .refresh_en, .dma_controller_en,
		.peripheral_clk_en, .osc_en, .system_clock_output_en, .reset_seq_start,
		.int_response, .nmi_response, .resume_next);
	pdm_bus_master_model i_pdm_bus_master_model (.clk, .want,
		.bus_grant_output_n, .bus_request_input_n, .granted);
	task automatic print_verdict;
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_bit(string what, logic exp, logic got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic avm(logic w, logic [3:0] a, logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= ~w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		logic [31:0] q;
		avm(1'b1, a, d, q);
	endtask
	task automatic idle(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_hi(string what, ref logic s, input int n);
		repeat (n) begin
			@(negedge clk);
			if (s === 1'b1) return;
		end
		chk_bit(what, 1'b1, s);
	endtask
	task automatic instr(logic h);
		@(posedge clk);
		halt_exec <= h;
		sleep_instruction <= ~h;
		@(posedge clk);
		halt_exec <= 1'b0;
		sleep_instruction <= 1'b0;
	endtask
	task automatic pin_reset;
		@(posedge clk) reset_pin_n <= 1'b0;
		repeat (PDM_RESET_MIN_CLOCKS) @(posedge clk);
		reset_pin_n <= 1'b1;
		wait_hi("reset sequence", reset_seq_start, 4);
	endtask
	task automatic t_regs;
		logic [31:0] q;
		wr(PDM_OFS_IO_CTRL, 8'hFF);
		avm(1'b0, PDM_OFS_IO_CTRL, 8'h00, q);
		chk_word("io control", 32'hE0, q);
		chk_bit("periph stopped", 1'b0, peripheral_clk_en);
		chk_bit("cpu running", 1'b1, cpu_clk_en);
		avm(1'b0, 4'h2, 8'h00, q);
		chk_word("unmapped", 32'h0, q);
		wr(PDM_OFS_IO_CTRL, 8'h00);
		idle(2);
		chk_bit("periph resumed", 1'b1, peripheral_clk_en);
	endtask
	task automatic t_halt;
		wr(PDM_OFS_INT_EN, 8'h01);
		instr(1'b1);
		idle(2);
		chk_bit("halt_n", 1'b0, halt_n);
		chk_bit("halt cpu clock", 1'b1, cpu_clk_en);
		chk_bit("dummy fetch", 1'b1, halt_dummy_fetch);
		@(posedge clk) ext_int_req <= 3'h1;
		idle(5);
		chk_bit("masked halt", 1'b0, halt_n);
		@(posedge clk) gie <= 1'b1;
		wait_hi("int response", int_response, 8);
		chk_bit("halt exit", 1'b1, halt_n);
		@(posedge clk) ext_int_req <= 3'h0;
		gie <= 1'b0;
		instr(1'b1);
		@(posedge clk) want <= 1'b1;
		wait_hi("halt grant", granted, 6);
		chk_bit("halt bus float", 1'b1, bus_float);
		chk_bit("halt still", 1'b0, halt_n);
		@(posedge clk) want <= 1'b0;
		@(posedge clk) nmi_n <= 1'b0;
		wait_hi("halt nmi", nmi_response, 6);
		@(posedge clk) nmi_n <= 1'b1;
		instr(1'b1);
		pin_reset();
		chk_bit("halt reset exit", 1'b1, halt_n);
	endtask
	task automatic t_sysstop;
		wr(PDM_OFS_IO_CTRL, 8'h20);
		wr(PDM_OFS_INT_EN, 8'h09);
		instr(1'b0);
		idle(3);
		chk_bit("stop cpu clock", 1'b0, cpu_clk_en);
		chk_bit("stop periph", 1'b0, peripheral_clk_en);
		chk_bit("stop clock out", 1'b1, system_clock_output_en);
		@(posedge clk) pint <= 1'b1;
		idle(6);
		chk_bit("periph no wake", 1'b0, cpu_clk_en);
		@(posedge clk) begin
			ext_int_req <= 3'h1;
			gie <= 1'b1;
		end
		wait_hi("stop int response", int_response, 8);
		@(posedge clk) begin
			ext_int_req <= 3'h0;
			gie <= 1'b0;
			pint <= 1'b0;
		end
	endtask
	task automatic t_sleep(int kind);
		wr(PDM_OFS_INT_EN, 8'h01);
		instr(1'b0);
		idle(3);
		chk_bit("sleep cpu clock", 1'b0, cpu_clk_en);
		chk_bit("sleep dma", 1'b0, dma_controller_en);
		chk_bit("sleep osc", 1'b1, osc_en);
		chk_bit("sleep periph", 1'b1, peripheral_clk_en);
		chk_bit("sleep address", 1'b1, address_outputs_high);
		@(posedge clk) ext_int_req <= 3'h2;
		idle(5);
		chk_bit("disabled int", 1'b0, cpu_clk_en);
		case (kind)
			0: begin
				@(posedge clk) ext_int_req <= 3'h3;
				wait_hi("resume next", resume_next, 8);
			end
			1: begin
				@(posedge clk) nmi_n <= 1'b0;
				wait_hi("nmi response", nmi_response, 8);
			end
			default: pin_reset();
		endcase
		chk_bit("awake", 1'b1, cpu_clk_en);
		@(posedge clk) ext_int_req <= 3'h0;
		nmi_n <= 1'b1;
	endtask
	task automatic t_idle;
		wr(PDM_OFS_CPU_CTRL, 8'h08);
		wr(PDM_OFS_IO_CTRL, 8'h20);
		wr(PDM_OFS_INT_EN, 8'h01);
		instr(1'b0);
		idle(3);
		chk_bit("idle osc", 1'b1, osc_en);
		chk_bit("idle clock out", 1'b0, system_clock_output_en);
		@(posedge clk) ext_int_req <= 3'h1;
		wait_hi("idle wake", resume_next, 14);
		@(posedge clk) ext_int_req <= 3'h0;
	endtask
	task automatic t_standby;
		wr(PDM_OFS_CPU_CTRL, 8'h40);
		instr(1'b0);
		@(posedge clk) want <= 1'b1;
		idle(40);
		chk_bit("standby osc", 1'b0, osc_en);
		chk_bit("standby system_clock_output", 1'b0, system_clock_output_en);
		@(posedge clk) ext_int_req <= 3'h1;
		idle(5);
		@(posedge clk) ext_int_req <= 3'h0;
		idle(3);
		chk_bit("dropped source", 1'b0, osc_en);
		@(posedge clk) ext_int_req <= 3'h1;
		idle(15);
		chk_bit("full recount", 1'b0, cpu_clk_en);
		wait_hi("int wake", resume_next, 40);
		idle(2);
		chk_bit("bus kept released", 1'b1, granted);
		@(posedge clk) ext_int_req <= 3'h0;
		want <= 1'b0;
		wr(PDM_OFS_CPU_CTRL, 8'h60);
		instr(1'b0);
		idle(3);
		@(posedge clk) want <= 1'b1;
		wait_hi("bus wake grant", granted, 40);
		chk_bit("address floated", 1'b1, bus_float);
		@(posedge clk) want <= 1'b0;
		wait_hi("bus return", resume_next, 8);
		chk_bit("bus retaken", 1'b0, bus_float);
		wr(PDM_OFS_CPU_CTRL, 8'h48);
		instr(1'b0);
		idle(3);
		@(posedge clk) ext_int_req <= 3'h1;
		idle(PDM_QUICK_CYCLES - 8);
		chk_bit("quick not early", 1'b0, cpu_clk_en);
		wait_hi("quick wake", resume_next, 16);
		@(posedge clk) ext_int_req <= 3'h0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_halt();
		for (int k = 0; k < 3; k++) t_sleep(k);
		t_sysstop();
		t_idle();
		t_standby();
		print_verdict();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
endmodule
